// *** design/scx_exception_regs.sv ***
// System-control exception registers behind an APB slave port
//
// Functional notes
// - Keyed writes act only with key 0x5FA
// - Key field reads back as 0xFA05
// - Byte order bit always reads little endian
// - Keyed write of bit 2 requests reset
// - Reset request held until system reset clears
// - Keyed bit 1 clears active state, self-clears
// - Priorities two bits, top of byte lane
// - Unused priority bits read zero, ignore writes
// - Priority fields at their two word addresses
// - Bit 15 shows and sets call pending
//
// The APB slave port was chosen for this implementation.
module scx_exception_regs
  import scx_pkg::*;
#(
  parameter int ADDR_W = 32
) (
  input  wire logic          core_clk,
  input  wire logic          sys_rst,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [31:0]   paddr,
  input  wire logic [31:0]   pwdata,
  input  wire logic [3:0]    pstrb,
  output logic               pready,
  output logic [31:0]        prdata,
  output logic               pslverr,
  input  wire logic          svcPendSet,
  input  wire logic          svcPendClr,
  output scx_prio_type       prioOut,
  output logic               supervisorCallPending,
  output logic               systemResetRequest,
  output logic               clearActiveState
);

  // Full 32-bit decode is needed for the fixed word addresses
  if (ADDR_W != 32) begin : g_bad_width
    $error("scx_exception_regs: ADDR_W must be 32");
  end

  scx_state_type stateQ;
  scx_state_type stateD;
  logic          setupPh;
  logic          wrDone;
  logic          keyOk;
  logic          hitAirc;
  logic          hitSvPri;
  logic          hitTkPri;
  logic          hitHcs;
  logic          hitAny;

  // Phase and decode terms
  assign setupPh  = psel && !penable;
  assign wrDone   = psel && penable && pwrite;
  assign keyOk    = pwdata[SCX_KEY_MSB:SCX_KEY_LSB] == SCX_WRITE_KEY;
  assign hitAirc  = paddr == SCX_ADDR_AIRC;
  assign hitSvPri = paddr == SCX_ADDR_SVPRI;
  assign hitTkPri = paddr == SCX_ADDR_TKPRI;
  assign hitHcs   = paddr == SCX_ADDR_HCS;
  assign hitAny   = hitAirc || hitSvPri || hitTkPri || hitHcs;

  // Zero wait states: read data is captured during the setup cycle
  assign pready  = psel && penable;
  assign prdata  = stateQ.rdata;
  assign pslverr = psel && penable && stateQ.slvErr;

  assign prioOut               = stateQ.prio;
  assign supervisorCallPending = stateQ.svcPending;
  assign systemResetRequest    = stateQ.resetReq;
  assign clearActiveState      = stateQ.clrActive;

  // Next-state logic for every register of the block
  always_comb begin
    stateD           = stateQ;
    stateD.clrActive = 1'b0;
    // Read data and error flag prepared in the setup cycle
    if (setupPh) begin
      stateD.rdata  = SCX_DATA_RST;
      stateD.slvErr = 1'b0;
      if (hitAirc) begin
        stateD.rdata[SCX_KEY_MSB:SCX_KEY_LSB] = SCX_READ_KEY;
        stateD.rdata[SCX_BYTE_ORDER] = 1'b0;
        stateD.rdata[SCX_RESET_BIT] = stateQ.resetReq;
      end else if (hitSvPri) begin
        stateD.rdata[SCX_PRI_B3 +: SCX_PRI_W] =
          stateQ.prio.supervisorCall;
      end else if (hitTkPri) begin
        stateD.rdata[SCX_PRI_B3 +: SCX_PRI_W] =
          stateQ.prio.tickTimer;
        stateD.rdata[SCX_PRI_B2 +: SCX_PRI_W] = stateQ.prio.deferredService;
        stateD.rdata[SCX_PRI_B1 +: SCX_PRI_W] = stateQ.prio.reservedHigh;
        stateD.rdata[SCX_PRI_B0 +: SCX_PRI_W] = stateQ.prio.reservedLow;
      end else if (hitHcs) begin
        stateD.rdata[SCX_SVC_PEND_BIT] = stateQ.svcPending;
      end else begin
        stateD.slvErr = 1'b1;
      end
    end
    // Writes take effect at the completing access edge only
    if (wrDone) begin
      if (hitAirc) begin
        // A wrong key leaves the whole word without effect
        if (keyOk && pstrb[0] && pwdata[SCX_RESET_BIT]) begin
          stateD.resetReq = 1'b1;
        end
        if (keyOk && pstrb[0] && pwdata[SCX_CLR_ACT_BIT]) begin
          stateD.clrActive = 1'b1;
        end
      end else if (hitSvPri) begin
        if (pstrb[3]) begin
          stateD.prio.supervisorCall =
            pwdata[SCX_PRI_B3 +: SCX_PRI_W];
        end
      end else if (hitTkPri) begin
        // Only the two top bits of each lane are stored
        if (pstrb[3]) begin
          stateD.prio.tickTimer = pwdata[SCX_PRI_B3 +: SCX_PRI_W];
        end
        if (pstrb[2]) begin
          stateD.prio.deferredService = pwdata[SCX_PRI_B2 +: SCX_PRI_W];
        end
        if (pstrb[1]) begin
          stateD.prio.reservedHigh = pwdata[SCX_PRI_B1 +: SCX_PRI_W];
        end
        if (pstrb[0]) begin
          stateD.prio.reservedLow = pwdata[SCX_PRI_B0 +: SCX_PRI_W];
        end
      end else if (hitHcs) begin
        if (pstrb[1]) begin
          stateD.svcPending = pwdata[SCX_SVC_PEND_BIT];
        end
      end
    end
    // Core events: a set wins over any clear in the same cycle
    if (svcPendClr) begin
      stateD.svcPending = 1'b0;
    end
    if (svcPendSet) begin
      stateD.svcPending = 1'b1;
    end
  end

  // Reset request stays up until the product reset clears it
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      stateQ <= '0;
    end else begin
      stateQ <= stateD;
    end
  end

  // Checks: all on the core clock, all asleep while the product resets
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);

  // Key gating: a wrong key or a missing low lane changes nothing
  a_key_gates_reset: assert property (
    (wrDone && hitAirc && !keyOk && !stateQ.resetReq) |=> !systemResetRequest)
    else $error("reset request set without key");
  a_key_gates_clear: assert property (
    (wrDone && hitAirc && !keyOk) |=> !clearActiveState)
    else $error("clear active raised without key");
  a_strobe_gates_key: assert property (
    (wrDone && hitAirc && !pstrb[0]) |=> !clearActiveState)
    else $error("clear active raised without low lane");

  // Control word readback: fixed key, little endian, live request bit
  a_key_readback: assert property (
    (setupPh && hitAirc) ##1 pready |-> prdata[31:16] == 16'hfa05)
    else $error("key field read back wrong");
  a_little_endian: assert property (
    (setupPh && hitAirc) |=> !prdata[15])
    else $error("byte order bit not zero");
  a_ctrl_zeros: assert property (
    (setupPh && hitAirc) |=> (prdata & 32'h00007ffb) == '0)
    else $error("reserved control bits not zero");
  a_reset_bit_read: assert property (
    (setupPh && hitAirc) |=> prdata[2] == $past(systemResetRequest))
    else $error("reset request bit read back wrong");
  a_clear_reads_zero: assert property (
    (setupPh && hitAirc) |=> !prdata[1])
    else $error("clear active bit not read as zero");

  // Reset request: raised by a keyed write, only reset drops it
  a_reset_request: assert property (
    (wrDone && hitAirc && keyOk && pstrb[0] && pwdata[2]) |=>
      systemResetRequest [*3])
    else $error("reset request not raised and held");
  a_reset_sticky: assert property (
    $rose(systemResetRequest) |=> systemResetRequest)
    else $error("reset request dropped without reset");
  a_reset_quiet: assert property (
    (!systemResetRequest && !(wrDone && hitAirc)) |=> !systemResetRequest)
    else $error("reset request rose without a write");

  // Clear of active state: one pulse per keyed write of a one
  a_clear_pulse: assert property (
    (wrDone && hitAirc && keyOk && pstrb[0] && pwdata[1]) |=>
      clearActiveState ##1 !clearActiveState)
    else $error("clear active not a one-cycle pulse");
  a_clear_self: assert property (
    clearActiveState |=> !clearActiveState)
    else $error("clear active did not self-clear");
  a_clear_zero_write: assert property (
    (wrDone && hitAirc && !pwdata[1]) |=> !clearActiveState)
    else $error("writing zero raised clear active");

  // Priorities: two bits per lane, stored only by their own lane
  a_prio_store: assert property (
    (wrDone && hitTkPri && pstrb[2]) |=>
      prioOut.deferredService == $past(pwdata[23:22]))
    else $error("deferred priority not stored");
  a_tick_store: assert property (
    (wrDone && hitTkPri && pstrb[3]) |=>
      prioOut.tickTimer == $past(pwdata[31:30]))
    else $error("tick priority not stored");
  a_svc_store: assert property (
    (wrDone && hitSvPri && pstrb[3]) |=>
      prioOut.supervisorCall == $past(pwdata[31:30]))
    else $error("supervisor call priority not stored");
  a_unused_zero: assert property (
    (setupPh && (hitSvPri || hitTkPri)) |=> (prdata & 32'h3f3f3f3f) == '0)
    else $error("unused priority bits not zero");
  a_svc_low_zero: assert property (
    (setupPh && hitSvPri) |=> prdata[29:0] == '0)
    else $error("low lanes of call priority word not zero");
  a_prio_quiet: assert property (
    !(wrDone && (hitSvPri || hitTkPri)) |=> $stable(prioOut))
    else $error("priority changed without a write");

  // Priority readback at each word address
  a_svc_readback: assert property (
    (setupPh && hitSvPri) |=> prdata[31:30] == prioOut.supervisorCall)
    else $error("supervisor call priority readback wrong");
  a_tick_readback: assert property (
    (setupPh && hitTkPri) |=> prdata[31:30] == prioOut.tickTimer)
    else $error("tick priority readback wrong");
  a_deferred_readback: assert property (
    (setupPh && hitTkPri) |=> prdata[23:22] == prioOut.deferredService)
    else $error("deferred priority readback wrong");
  a_reserved_readback: assert property (
    (setupPh && hitTkPri) |=> {prdata[15:14], prdata[7:6]} ==
      {prioOut.reservedHigh, prioOut.reservedLow})
    else $error("reserved priority readback wrong");

  // Pending flag: core set beats core clear beats software write
  a_pend_set_wins: assert property (
    svcPendSet |=> supervisorCallPending)
    else $error("pending set lost");
  a_pend_clear: assert property (
    (svcPendClr && !svcPendSet) |=> !supervisorCallPending)
    else $error("pending clear lost");
  a_pend_sw_set: assert property (
    (wrDone && hitHcs && pstrb[1] && pwdata[15] && !svcPendClr) |=>
      supervisorCallPending)
    else $error("software pending set lost");
  a_pend_sw_clear: assert property (
    (wrDone && hitHcs && pstrb[1] && !pwdata[15] && !svcPendSet) |=>
      !supervisorCallPending)
    else $error("software pending clear lost");
  a_pend_quiet: assert property (
    !(svcPendSet || svcPendClr || (wrDone && hitHcs)) |=>
      $stable(supervisorCallPending))
    else $error("pending changed without a cause");
  a_pend_readback: assert property (
    (setupPh && hitHcs) |=>
      prdata == {16'h0000, $past(supervisorCallPending), 15'h0000})
    else $error("handler state word read back wrong");

  // Bus answer: zero wait states, errors only for unmapped words
  a_ready_access: assert property (
    pready == (psel && penable))
    else $error("ready outside the access phase");
  a_err_in_access: assert property (
    pslverr |-> (psel && penable))
    else $error("error flag outside the access phase");
  a_unmapped_err: assert property (
    (setupPh && !hitAny) ##1 (psel && penable) |-> pslverr)
    else $error("unmapped word not flagged");
  a_mapped_no_err: assert property (
    (setupPh && hitAny) ##1 (psel && penable) |-> !pslverr)
    else $error("mapped word flagged as error");
  a_unmapped_zero: assert property (
    (setupPh && !hitAny) |=> prdata == '0)
    else $error("unmapped word read not zero");

  c_keyed_reset: cover property (@(posedge core_clk) $rose(systemResetRequest));
  c_clear_active: cover property (@(posedge core_clk) clearActiveState);
  c_pend_write: cover property (@(posedge core_clk)
    wrDone && hitHcs && pwdata[15]);
  c_unmapped: cover property (@(posedge core_clk) pslverr);
  c_prio_write: cover property (@(posedge core_clk) wrDone && hitTkPri);

endmodule

// *** design/scx_pkg.sv ***
// Constants and carrier types for the system-control exception register group
package scx_pkg;

  // Byte addresses of the register words
  localparam logic [31:0] SCX_ADDR_AIRC  = 32'he000ed0c;
  localparam logic [31:0] SCX_ADDR_SVPRI = 32'he000ed1c;
  localparam logic [31:0] SCX_ADDR_TKPRI = 32'he000ed20;
  localparam logic [31:0] SCX_ADDR_HCS   = 32'he000ed24;

  // Application interrupt and reset control fields
  localparam int          SCX_KEY_MSB     = 31;
  localparam int          SCX_KEY_LSB     = 16;
  localparam logic [15:0] SCX_WRITE_KEY   = 16'h05fa;
  localparam logic [15:0] SCX_READ_KEY    = 16'hfa05;
  localparam int          SCX_BYTE_ORDER  = 15;
  localparam int          SCX_RESET_BIT   = 2;
  localparam int          SCX_CLR_ACT_BIT = 1;

  // Priority field positions, top two bits of each byte lane
  localparam int SCX_PRI_B3 = 30;
  localparam int SCX_PRI_B2 = 22;
  localparam int SCX_PRI_B1 = 14;
  localparam int SCX_PRI_B0 = 6;
  localparam int SCX_PRI_W  = 2;

  // Handler control and state field
  localparam int SCX_SVC_PEND_BIT = 15;

  // Reset values
  localparam logic [1:0]  SCX_PRI_RST  = 2'h0;
  localparam logic [31:0] SCX_DATA_RST = 32'h00000000;

  // Exception priorities seen by the core
  typedef struct packed {
    logic [1:0] supervisorCall;
    logic [1:0] tickTimer;
    logic [1:0] deferredService;
    logic [1:0] reservedHigh;
    logic [1:0] reservedLow;
  } scx_prio_type;

  // Whole register state of the block
  typedef struct packed {
    scx_prio_type prio;
    logic         resetReq;
    logic         clrActive;
    logic         svcPending;
    logic [31:0]  rdata;
    logic         slvErr;
  } scx_state_type;

endpackage

// *** dv/scx_core_model.sv ***
// Core and system reset logic facing the exception register group
module scx_core_model
  import scx_pkg::*;
(
  input  wire logic core_clk,
  input  wire logic setReq,
  input  wire logic clrReq,
  input  wire logic systemResetRequest,
  input  wire logic clearActiveState,
  output logic      svcPendSet,
  output logic      svcPendClr,
  output logic      rstOut,
  output int        clrSeen
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] rstCnt_q;

  initial begin
    {svcPendSet, svcPendClr, rstCnt_q} = '0;
    clrSeen = 0;
  end

  // Core requests leave on a clock edge, like the core's own flops
  always @(posedge core_clk) begin
    svcPendSet <= setReq;
    svcPendClr <= clrReq;
  end

  // Count clear pulses; a stuck pulse shows up as more than one
  always @(posedge core_clk) begin
    if (clearActiveState) begin
      clrSeen <= clrSeen + 1;
    end
  end

  // A request resets the whole product for three cycles
  always @(posedge core_clk) begin
    if (systemResetRequest) begin
      rstCnt_q <= 2'h3;
    end else if (rstCnt_q != 2'h0) begin
      rstCnt_q <= rstCnt_q - 2'h1;
    end
  end
  assign rstOut = (rstCnt_q != 2'h0);
endmodule

// *** dv/system_control_exception_regs_tb.sv ***
// Self-checking bench for the exception register group
module system_control_exception_regs_tb
  import scx_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic         core_clk, tbRst, sys_rst, psel, penable, pwrite, pready;
  logic         pslverr, err, setReq, clrReq, sPs, sPc, rstOut, pend;
  logic         rstReq, clrAct, rqSeen;
  logic [31:0]  paddr, pwdata, prdata, rd, d, a;
  logic [3:0]   pstrb;
  scx_prio_type prioOut;
  int           err_total, check_count, clrSeen;

  assign sys_rst = tbRst | rstOut;
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  initial rqSeen = 1'b0;
  always @(posedge rstReq) rqSeen = 1'b1;

  scx_exception_regs scx_exception_regs_inst (.core_clk(core_clk),
    .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .svcPendSet(sPs),
    .svcPendClr(sPc), .prioOut(prioOut), .supervisorCallPending(pend),
    .systemResetRequest(rstReq), .clearActiveState(clrAct));
  scx_core_model scx_core_model_inst (.core_clk(core_clk), .setReq(setReq),
    .clrReq(clrReq), .systemResetRequest(rstReq), .clearActiveState(clrAct),
    .svcPendSet(sPs), .svcPendClr(sPc), .rstOut(rstOut), .clrSeen(clrSeen));

  task automatic stop_test;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask

  // One APB transfer; request held until pready is seen at an edge
  task automatic apb(input logic w, input logic [31:0] ad, dt);
    int n;
    @(posedge core_clk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, ad, dt};
    @(posedge core_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      chk(32'h0, 32'h1);
      stop_test;
    end
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
    @(posedge core_clk);
  endtask

  // Expected read mask of a priority word
  function automatic logic [31:0] pmask(input logic [31:0] ad);
    return (ad == SCX_ADDR_SVPRI) ? 32'hc0000000 : 32'hc0c0c0c0;
  endfunction

  // Pulse one core pending request through the partner
  task automatic core(input logic s);
    if (s) setReq <= 1'b1;
    else clrReq <= 1'b1;
    @(posedge core_clk);
    {setReq, clrReq} <= 2'b00;
    repeat (2) @(posedge core_clk);
    apb(0, SCX_ADDR_HCS, 0);
    chk(rd, {16'h0, s, 15'h0});
  endtask

  initial begin
    {psel, penable, pwrite, setReq, clrReq, paddr, pwdata} = '0;
    pstrb = 4'hf;
    tbRst = 1'b1;
    void'($urandom(32'he72c6d9a));
    repeat (4) @(posedge core_clk);
    tbRst <= 1'b0;
    apb(0, SCX_ADDR_AIRC, 0);
    chk(rd, 32'hfa050000);
    apb(0, SCX_ADDR_HCS, 0);
    chk(rd, 32'h0);
    apb(0, 32'he000ed10, 0);
    chk({err, rd[30:0]}, 32'h80000000);
    $display("reset values done");
    // All-ones first, then random words on both priority registers
    for (int i = 0; i < 10; i++) begin
      d = (i < 2) ? 32'hffffffff : $urandom;
      a = i[0] ? SCX_ADDR_TKPRI : SCX_ADDR_SVPRI;
      apb(1, a, d);
      apb(0, a, 0);
      chk(rd, d & pmask(a));
      if (i[0]) chk({24'h0, prioOut[7:0]},
        {24'h0, d[31:30], d[23:22], d[15:14], d[7:6]});
      else chk({30'h0, prioOut.supervisorCall}, {30'h0, d[31:30]});
    end
    $display("priority test done");
    apb(1, SCX_ADDR_AIRC, 32'h05fafffb);
    apb(0, SCX_ADDR_AIRC, 0);
    chk(rd, 32'hfa050000);
    apb(1, SCX_ADDR_AIRC, 32'h05fb0006);
    pstrb <= 4'he;
    apb(1, SCX_ADDR_AIRC, 32'h05fa0006);
    pstrb <= 4'hf;
    repeat (4) @(posedge core_clk);
    chk(clrSeen, 1);
    chk({31'h0, rqSeen}, 32'h0);
    $display("key test done");
    apb(1, SCX_ADDR_HCS, 32'hffffffff);
    apb(0, SCX_ADDR_HCS, 0);
    chk(rd, 32'h00008000);
    core(1'b0);
    core(1'b1);
    apb(1, SCX_ADDR_HCS, 32'h0);
    chk({31'h0, pend}, 32'h0);
    $display("pending test done");
    apb(1, SCX_ADDR_AIRC, 32'h05fa0004);
    repeat (8) @(posedge core_clk);
    chk({31'h0, rqSeen}, 32'h1);
    chk({31'h0, rstReq}, 32'h0);
    apb(0, SCX_ADDR_TKPRI, 0);
    chk(rd, 32'h0);
    $display("reset request test done");
    stop_test;
  end
endmodule
